// >>> cit_timer.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "cit_cfg.svh"

module cit_timer #(
	parameter int FILT_STAGES = 5,
	parameter int PRESC_W = 6
) (
	input wire logic clk,
	input wire logic rst,
	input wire cit_pkg::cit_bus_req_t bus_req,
	output logic [7:0] rd_data,
	output logic irq,
	input wire logic capture_pin,
	input wire logic watch_clk_pin
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] mode_ff;
	logic [7:0] clk_stop_ff;
	logic [2:0] pin_ctrl_ff;
	logic irq_flag_ff;
	logic arm_high_ff;
	logic arm_low_ff;
	logic [7:0] cnt_ff;
	logic [7:0] cap_fall_ff;
	logic [7:0] cap_rise_ff;
	logic [7:0] rd_data_ff;
	logic irq_ff;
	logic [PRESC_W-1:0] presc_ff;
	logic [2:0] wsync_ff;
	logic wlvl_ff;
	logic [1:0] wdiv_ff;
	logic [2:0] csync_ff;
	logic clvl_ff;
	logic sel_prev_ff;
	logic [FILT_STAGES-1:0] latch_ff;
	logic filt_out_ff;
	logic filt_prev_ff;
	logic seen_high_ff;
	logic filt_init_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Field decode
	wire standby_rel = clk_stop_ff[`CIT_BIT_STANDBY_REL];
	wire capture_mode = pin_ctrl_ff[`CIT_BIT_PIN_FUNC];
	wire noise_en = pin_ctrl_ff[`CIT_BIT_NOISE_EN];
	wire irq_en = pin_ctrl_ff[`CIT_BIT_IRQ_EN];
	wire overflow_irq_enable = mode_ff[`CIT_BIT_OVERFLOW_IRQ_ENABLE];
	wire edge_sel = mode_ff[`CIT_BIT_EDGE_SEL];
	wire cit_pkg::cit_clr_t clr_sel = cit_pkg::cit_clr_t'(mode_ff[`CIT_BIT_CLR_HI:`CIT_BIT_CLR_LO]);
	wire cit_pkg::cit_cks_t cks_sel = cit_pkg::cit_cks_t'(mode_ff[`CIT_BIT_CKS_HI:`CIT_BIT_CKS_LO]);

	// Bus decode; the counter has no address on purpose
	wire wr_mode = bus_req.wr && bus_req.addr == `CIT_OFS_MODE;
	wire rd_mode = bus_req.rd && bus_req.addr == `CIT_OFS_MODE;
	wire wr_stop = bus_req.wr && bus_req.addr == `CIT_OFS_CLK_STOP;
	wire wr_pin = bus_req.wr && bus_req.addr == `CIT_OFS_PIN_CTRL;
	wire wr_irq = bus_req.wr && bus_req.addr == `CIT_OFS_IRQ;

	////////////////////////////////////////////////////////////////////////////////
	// Clock sources: free prescaler and a three-stage watch clock synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			presc_ff <= '0;
			wsync_ff <= 3'h0;
			wlvl_ff <= 1'b0;
			wdiv_ff <= 2'h0;
		end else begin
			presc_ff <= presc_ff + 1'b1;
			wsync_ff <= {wsync_ff[1:0], watch_clk_pin};
			if (wsync_ff[1] == wsync_ff[2])
				wlvl_ff <= wsync_ff[2];
			if (wsync_ff[2] == wsync_ff[1] && wsync_ff[2] && !wlvl_ff)
				wdiv_ff <= wdiv_ff + 1'b1;
		end
	end

	// Selected count clock level; a switch from high to low counts once, as in silicon
	wire sel_lvl = (cks_sel == cit_pkg::CIT_CKS_DIV64) ? presc_ff[5] :
		(cks_sel == cit_pkg::CIT_CKS_DIV32) ? presc_ff[4] :
		(cks_sel == cit_pkg::CIT_CKS_DIV2) ? presc_ff[0] : wdiv_ff[1];
	wire sel_rise = sel_lvl && !sel_prev_ff;
	wire cnt_tick = !sel_lvl && sel_prev_ff && standby_rel;
	// Filter samples every cycle outside standby unless noise filtering picks the count clock
	wire samp_tick = standby_rel && (noise_en ? sel_rise : 1'b1);

	////////////////////////////////////////////////////////////////////////////////
	// Capture pin synchroniser; level changes once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			csync_ff <= 3'h0;
			clvl_ff <= 1'b0;
			sel_prev_ff <= 1'b0;
		end else begin
			csync_ff <= {csync_ff[1:0], capture_pin};
			if (csync_ff[1] == csync_ff[2])
				clvl_ff <= csync_ff[2];
			sel_prev_ff <= sel_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Noise filter latch chain
	genvar gi;
	generate
		for (gi = 0; gi < FILT_STAGES; gi++) begin : g_latch
			always_ff @(posedge clk) begin
				if (rst)
					latch_ff[gi] <= 1'b0;
				else if (samp_tick)
					latch_ff[gi] <= (gi == 0) ? clvl_ff : latch_ff[(gi == 0) ? 0 : gi-1];
			end
		end
	endgenerate

	wire all_high = &latch_ff;
	wire all_low = ~|latch_ff;

	// Output moves only on full agreement, so an edge arrives five samples late
	always_ff @(posedge clk) begin
		if (rst) begin
			filt_out_ff <= 1'b0;
			filt_prev_ff <= 1'b0;
			seen_high_ff <= 1'b0;
			filt_init_ff <= 1'b0;
		end else begin
			if (all_high)
				filt_out_ff <= 1'b1;
			else if (all_low)
				filt_out_ff <= 1'b0;
			filt_prev_ff <= filt_out_ff;
			if (latch_ff[0])
				seen_high_ff <= 1'b1; // A high must reach the chain, not only the pin
			// Arming once the output sits low keeps the first fall from looking like an edge
			if (seen_high_ff && all_low && !filt_out_ff)
				filt_init_ff <= 1'b1;
		end
	end

	// Edges count only in capture mode and after initialisation
	wire edge_ok = filt_init_ff && capture_mode;
	wire rise_evt = edge_ok && filt_out_ff && !filt_prev_ff;
	wire fall_evt = edge_ok && !filt_out_ff && filt_prev_ff;
	wire clr_evt = (rise_evt && mode_ff[`CIT_BIT_CLR_HI]) || (fall_evt && mode_ff[`CIT_BIT_CLR_LO]);

	////////////////////////////////////////////////////////////////////////////////
	// Counter and capture registers
	wire wrap = cnt_tick && cnt_ff == `CIT_CNT_MAX && !clr_evt;
	wire set_high = wrap && capture_mode && filt_out_ff;
	wire set_low = wrap && !(capture_mode && filt_out_ff);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= `CIT_RST_COUNT;
			cap_fall_ff <= `CIT_RST_COUNT;
			cap_rise_ff <= `CIT_RST_COUNT;
		end else begin
			if (clr_evt)
				cnt_ff <= `CIT_RST_COUNT;
			else if (cnt_tick)
				cnt_ff <= cnt_ff + 1'b1;
			if (rise_evt)
				cap_rise_ff <= cnt_ff;
			if (fall_evt)
				cap_fall_ff <= cnt_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Overflow flags: a read of one arms the clear, a set beats a clear
	wire clr_high = wr_mode && !bus_req.wdata[`CIT_BIT_OVF_HIGH] && arm_high_ff;
	wire clr_low = wr_mode && !bus_req.wdata[`CIT_BIT_OVF_LOW] && arm_low_ff;
	wire nxt_ovf_high = set_high || (mode_ff[`CIT_BIT_OVF_HIGH] && !clr_high);
	wire nxt_ovf_low = set_low || (mode_ff[`CIT_BIT_OVF_LOW] && !clr_low);
	wire [5:0] nxt_mode_ctl = wr_mode ? bus_req.wdata[5:0] : mode_ff[5:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_ff <= `CIT_RST_MODE;
			arm_high_ff <= 1'b0;
			arm_low_ff <= 1'b0;
			clk_stop_ff <= `CIT_RST_CLK_STOP;
			pin_ctrl_ff <= `CIT_RST_PIN_CTRL;
		end else begin
			mode_ff <= {nxt_ovf_high, nxt_ovf_low, nxt_mode_ctl};
			if (rd_mode) begin
				arm_high_ff <= mode_ff[`CIT_BIT_OVF_HIGH];
				arm_low_ff <= mode_ff[`CIT_BIT_OVF_LOW];
			end else if (wr_mode) begin
				arm_high_ff <= 1'b0;
				arm_low_ff <= 1'b0;
			end
			if (wr_stop)
				clk_stop_ff <= bus_req.wdata;
			if (wr_pin)
				pin_ctrl_ff <= bus_req.wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timer request flag; an edge or an overflow in the clearing cycle still lands
	wire cap_irq_evt = edge_sel ? fall_evt : rise_evt;
	wire ovf_irq_evt = overflow_irq_enable && (set_high || set_low);
	wire irq_clr = wr_irq && !bus_req.wdata[`CIT_BIT_IRQ_FLAG];
	wire nxt_irq_flag = cap_irq_evt || ovf_irq_evt || (irq_flag_ff && !irq_clr);

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			irq_flag_ff <= nxt_irq_flag;
			irq_ff <= nxt_irq_flag && irq_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid the cycle after the read strobe; unmapped reads give zero
	wire [7:0] rd_mux = (bus_req.addr == `CIT_OFS_MODE) ? mode_ff :
		(bus_req.addr == `CIT_OFS_CAP_FALL) ? cap_fall_ff :
		(bus_req.addr == `CIT_OFS_CAP_RISE) ? cap_rise_ff :
		(bus_req.addr == `CIT_OFS_CLK_STOP) ? clk_stop_ff :
		(bus_req.addr == `CIT_OFS_PIN_CTRL) ? {5'h00, pin_ctrl_ff} :
		(bus_req.addr == `CIT_OFS_IRQ) ? {7'h00, irq_flag_ff} : 8'h00;

	always_ff @(posedge clk) begin
		if (rst)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= bus_req.rd ? rd_mux : 8'h00;
	end

	assign rd_data = rd_data_ff;
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	no_sw_set_a: assert property (@(posedge clk) disable iff (rst)
		(wr_mode && bus_req.wdata[7] && !mode_ff[7] && !set_high) |=> !mode_ff[7])
		else $error("overflow high flag set by software");

	ovf_high_a: assert property (@(posedge clk) disable iff (rst)
		(wrap && capture_mode && filt_out_ff) |=> mode_ff[7] && cnt_ff == 8'h00)
		else $error("high overflow not flagged");

	ovf_low_a: assert property (@(posedge clk) disable iff (rst)
		(wrap && !capture_mode) |=> mode_ff[6] && cnt_ff == 8'h00)
		else $error("low overflow not flagged in interval mode");

	clr_armed_a: assert property (@(posedge clk) disable iff (rst)
		(mode_ff[6] && wr_mode && !arm_low_ff) |=> mode_ff[6])
		else $error("low flag cleared without prior read");

	overflow_irq_enable_gate_a: assert property (@(posedge clk) disable iff (rst)
		(!overflow_irq_enable && !irq_flag_ff && wrap && !cap_irq_evt) |=> !irq_flag_ff)
		else $error("overflow request while disabled");

	edge_irq_a: assert property (@(posedge clk) disable iff (rst)
		(edge_sel ? fall_evt : rise_evt) |=> irq_flag_ff && irq == $past(irq_en))
		else $error("selected edge did not raise request");

	rise_clear_a: assert property (@(posedge clk) disable iff (rst)
		(rise_evt && clr_sel == cit_pkg::CIT_CLR_RISE) |=> cnt_ff == 8'h00)
		else $error("rising edge did not clear counter");

	filt_hold_a: assert property (@(posedge clk) disable iff (rst)
		(!all_high && !all_low) |=> $stable(filt_out_ff))
		else $error("filter output moved without agreement");

	cap_copy_a: assert property (@(posedge clk) disable iff (rst)
		fall_evt |=> cap_fall_ff == $past(cnt_ff))
		else $error("falling capture missed");

	standby_a: assert property (@(posedge clk) disable iff (rst)
		(!standby_rel && !clr_evt) |=> $stable(cnt_ff))
		else $error("counter moved in standby");

	no_sw_low_a: assert property (@(posedge clk) disable iff (rst)
		(wr_mode && bus_req.wdata[6] && !mode_ff[6] && !set_low) |=> !mode_ff[6])
		else $error("overflow low flag set by software");

	ovf_low_cap_a: assert property (@(posedge clk) disable iff (rst)
		(wrap && capture_mode && !filt_out_ff) |=> mode_ff[6])
		else $error("low overflow not flagged in capture mode");

	ovf_irq_a: assert property (@(posedge clk) disable iff (rst)
		(overflow_irq_enable && wrap) |=> irq_flag_ff)
		else $error("enabled overflow did not raise request");

	interval_only_a: assert property (@(posedge clk) disable iff (rst)
		(wrap && !capture_mode && !mode_ff[7]) |=> !mode_ff[7])
		else $error("high flag set in interval mode");

	fall_clear_a: assert property (@(posedge clk) disable iff (rst)
		(fall_evt && mode_ff[`CIT_BIT_CLR_LO]) |=> cnt_ff == 8'h00)
		else $error("falling edge did not clear counter");

	no_clear_a: assert property (@(posedge clk) disable iff (rst)
		(clr_sel == cit_pkg::CIT_CLR_NONE && !cnt_tick) |=> $stable(cnt_ff))
		else $error("counter changed with clearing disabled");

	set_wins_a: assert property (@(posedge clk) disable iff (rst)
		(set_low && wr_mode && !bus_req.wdata[6]) |=> mode_ff[6])
		else $error("overflow lost to a clearing write");

	irq_level_a: assert property (@(posedge clk) disable iff (rst)
		irq |-> irq_flag_ff && $past(irq_en))
		else $error("interrupt without flag or enable");

	mode_gate_a: assert property (@(posedge clk) disable iff (rst)
		!capture_mode |=> $stable(cap_rise_ff) && $stable(cap_fall_ff))
		else $error("capture taken in interval mode");

	init_gate_a: assert property (@(posedge clk) disable iff (rst)
		!filt_init_ff |=> $stable(cap_rise_ff) && $stable(cap_fall_ff))
		else $error("capture taken before filter initialised");

	init_low_a: assert property (@(posedge clk) disable iff (rst)
		$rose(filt_init_ff) |-> $past(all_low) && !filt_out_ff)
		else $error("filter initialised without low samples");

	filt_rise_a: assert property (@(posedge clk) disable iff (rst)
		$rose(filt_out_ff) |-> $past(all_high))
		else $error("filter rose before five high samples");

	filt_fall_a: assert property (@(posedge clk) disable iff (rst)
		$fell(filt_out_ff) |-> $past(all_low))
		else $error("filter fell before five low samples");

	samp_hold_a: assert property (@(posedge clk) disable iff (rst)
		(noise_en && !sel_rise) |=> $stable(latch_ff))
		else $error("filter sampled off the count clock edge");

	samp_sys_a: assert property (@(posedge clk) disable iff (rst)
		(!noise_en && standby_rel) |=> latch_ff[0] == $past(clvl_ff))
		else $error("filter missed a system clock sample");

	standby_filt_a: assert property (@(posedge clk) disable iff (rst)
		!standby_rel |=> $stable(latch_ff))
		else $error("filter sampled in standby");

	rise_copy_a: assert property (@(posedge clk) disable iff (rst)
		rise_evt |=> cap_rise_ff == $past(cnt_ff))
		else $error("rising capture missed");

	// Checked without the reset guard, at the first edge that sees reset low
	reset_val_a: assert property (@(posedge clk)
		$fell(rst) |-> mode_ff == `CIT_RST_MODE && cnt_ff == `CIT_RST_COUNT &&
		cap_rise_ff == `CIT_RST_COUNT && cap_fall_ff == `CIT_RST_COUNT)
		else $error("registers not at reset values");

endmodule // cit_timer

// >>> cit_cfg.svh
`ifndef CIT_CFG_SVH
`define CIT_CFG_SVH
// Register offsets on the plain register port
`define CIT_OFS_MODE 3'h0
`define CIT_OFS_CAP_FALL 3'h1
`define CIT_OFS_CAP_RISE 3'h2
`define CIT_OFS_CLK_STOP 3'h3
`define CIT_OFS_PIN_CTRL 3'h4
`define CIT_OFS_IRQ 3'h5
// Mode register fields
`define CIT_BIT_OVF_HIGH 7
`define CIT_BIT_OVF_LOW 6
`define CIT_BIT_OVERFLOW_IRQ_ENABLE 5
`define CIT_BIT_EDGE_SEL 4
`define CIT_BIT_CLR_HI 3
`define CIT_BIT_CLR_LO 2
`define CIT_BIT_CKS_HI 1
`define CIT_BIT_CKS_LO 0
// Clock stop register, standby release bit
`define CIT_BIT_STANDBY_REL 3
// Pin control register fields
`define CIT_BIT_PIN_FUNC 0
`define CIT_BIT_NOISE_EN 1
`define CIT_BIT_IRQ_EN 2
// Irq register field
`define CIT_BIT_IRQ_FLAG 0
// Reset values and the counter maximum
`define CIT_RST_MODE 8'h00
`define CIT_RST_CLK_STOP 8'hFF
`define CIT_RST_PIN_CTRL 3'h0
`define CIT_RST_COUNT 8'h00
`define CIT_CNT_MAX 8'hFF
`endif

// >>> cit_pkg.sv
package cit_pkg;
	// One register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} cit_bus_req_t;
	// Counter clear selection
	typedef enum logic [1:0] {
		CIT_CLR_NONE,
		CIT_CLR_FALL,
		CIT_CLR_RISE,
		CIT_CLR_BOTH
	} cit_clr_t;
	// Count clock selection
	typedef enum logic [1:0] {
		CIT_CKS_DIV64,
		CIT_CKS_DIV32,
		CIT_CKS_DIV2,
		CIT_CKS_WDIV4
	} cit_cks_t;
endpackage

// >>> cit_pulse_src.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Pulse source on the capture pin; it always drives, so the pin never floats
module cit_pulse_src (
	input wire logic clk,
	output logic pin
);
	initial pin = 1'b0;
	// High for hi clocks, then low for lo clocks; a short hi is a deliberate glitch
	task automatic pulse(input int hi, input int lo);
		@(posedge clk);
		pin <= 1'b1;
		repeat (hi) @(posedge clk);
		pin <= 1'b0;
		repeat (lo) @(posedge clk);
	endtask
endmodule // cit_pulse_src

// >>> tb_top.sv
`timescale 1ns/100ps
`include "cit_cfg.svh"
module tb_top;
	logic clk;
	logic rst;
	cit_pkg::cit_bus_req_t bus_req;
	logic [7:0] rd_data;
	logic irq;
	logic capture_pin;
	logic watch_clk_pin;
	logic [7:0] d;
	logic [7:0] e;
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;

	cit_timer i_cit_timer (.clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
		.irq(irq), .capture_pin(capture_pin), .watch_clk_pin(watch_clk_pin));
	cit_pulse_src i_cit_pulse_src (.clk(clk), .pin(capture_pin));

	////////////////////////////////////////////////////////////////
	// System clock and an unrelated slow watch clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		watch_clk_pin = 1'b0;
		forever #610 watch_clk_pin = ~watch_clk_pin;
	end
	// Hang guard; the tests need well under 6000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= v;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 v = rd_data;
	endtask
	task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] x);
		logic [7:0] v;
		rd_reg(a, v);
		check(n, v, x);
	endtask
	// Capture values carry a one-count jitter from the edge path, so judge a window
	task automatic in_rng(input string n, input logic [7:0] v, input int lo, input int hi);
		check(n, (v >= lo && v <= hi) ? 8'h01 : 8'h00, 8'h01);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk("mode", `CIT_OFS_MODE, 8'h00);
		rd_chk("cap_fall", `CIT_OFS_CAP_FALL, 8'h00);
		rd_chk("cap_rise", `CIT_OFS_CAP_RISE, 8'h00);
		rd_chk("clk_stop", `CIT_OFS_CLK_STOP, 8'hFF);
		rd_chk("unmapped", 3'h6, 8'h00);
		check("irq", {7'h00, irq}, 8'h00);
		$display("test reset done");
	endtask
	// Interval mode at clock over 2 with overflow requests enabled
	task automatic t_interval;
		wr_reg(`CIT_OFS_MODE, 8'hE2);
		rd_chk("mode_wr1", `CIT_OFS_MODE, 8'h22);
		for (int i = 0; i < 700; i++) begin
			rd_reg(`CIT_OFS_MODE, d);
			if (d[6] === 1'b1) break;
		end
		check("ovf_interval", d, 8'h62);
		rd_chk("irq_flag", `CIT_OFS_IRQ, 8'h01);
		wr_reg(`CIT_OFS_MODE, 8'h62);
		wr_reg(`CIT_OFS_MODE, 8'h22);
		rd_chk("clr_unarmed", `CIT_OFS_MODE, 8'h62);
		wr_reg(`CIT_OFS_MODE, 8'h22);
		rd_chk("clr_armed", `CIT_OFS_MODE, 8'h22);
		wr_reg(`CIT_OFS_PIN_CTRL, 8'h04);
		repeat (2) @(posedge clk);
		#1 check("irq_pin", {7'h00, irq}, 8'h01);
		$display("test interval done");
	endtask
	// Capture mode, filter off; first pulse initialises the filter
	task automatic t_capture;
		wr_reg(`CIT_OFS_MODE, 8'h0E);
		wr_reg(`CIT_OFS_PIN_CTRL, 8'h05);
		wr_reg(`CIT_OFS_IRQ, 8'h00);
		i_cit_pulse_src.pulse(10, 30);
		rd_chk("no_init_fall", `CIT_OFS_CAP_FALL, 8'h00);
		rd_chk("no_init_irq", `CIT_OFS_IRQ, 8'h00);
		i_cit_pulse_src.pulse(40, 40);
		rd_reg(`CIT_OFS_CAP_FALL, d);
		in_rng("width_both", d, 19, 21);
		rd_chk("irq_rise", `CIT_OFS_IRQ, 8'h01);
		wr_reg(`CIT_OFS_MODE, 8'h16);
		wr_reg(`CIT_OFS_IRQ, 8'h00);
		i_cit_pulse_src.pulse(40, 40);
		rd_reg(`CIT_OFS_CAP_RISE, e);
		rd_reg(`CIT_OFS_CAP_FALL, d);
		in_rng("width_fall", d - e, 19, 21);
		rd_chk("irq_fall", `CIT_OFS_IRQ, 8'h01);
		$display("test capture done");
	endtask
	// Filter on at clock over 2: a glitch under five samples is dropped
	task automatic t_filter;
		wr_reg(`CIT_OFS_MODE, 8'h0E);
		wr_reg(`CIT_OFS_PIN_CTRL, 8'h07);
		repeat (40) @(posedge clk);
		wr_reg(`CIT_OFS_IRQ, 8'h00);
		i_cit_pulse_src.pulse(5, 40);
		rd_chk("glitch", `CIT_OFS_IRQ, 8'h00);
		i_cit_pulse_src.pulse(30, 40);
		rd_chk("filtered", `CIT_OFS_IRQ, 8'h01);
		wr_reg(`CIT_OFS_CLK_STOP, 8'hF7);
		wr_reg(`CIT_OFS_IRQ, 8'h00);
		i_cit_pulse_src.pulse(30, 40);
		rd_chk("standby", `CIT_OFS_IRQ, 8'h00);
		$display("test filter done");
	endtask
	// Remaining count clocks, filter off: a pulse ten count periods long reads back near ten
	task automatic t_clksel;
		wr_reg(`CIT_OFS_CLK_STOP, 8'hFF);
		wr_reg(`CIT_OFS_PIN_CTRL, 8'h05);
		wr_reg(`CIT_OFS_MODE, 8'h0C);
		i_cit_pulse_src.pulse(640, 20);
		rd_reg(`CIT_OFS_CAP_FALL, d);
		in_rng("div64", d, 9, 11);
		wr_reg(`CIT_OFS_MODE, 8'h0D);
		i_cit_pulse_src.pulse(320, 20);
		rd_reg(`CIT_OFS_CAP_FALL, d);
		in_rng("div32", d, 9, 11);
		wr_reg(`CIT_OFS_MODE, 8'h0F);
		i_cit_pulse_src.pulse(1220, 20);
		rd_reg(`CIT_OFS_CAP_FALL, d);
		in_rng("watch_div4", d, 9, 11);
		$display("test clksel done");
	endtask

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence: reset held 20 cycles, then each scenario in turn
	initial begin
		rst = 1'b1;
		bus_req = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_interval();
		t_capture();
		t_filter();
		t_clksel();
		report_and_stop();
	end
endmodule // tb_top
